/* design/cirx_core.sv */
// Consumer infrared transceiver: registers, receiver, transmitter
// Summary of operation
// - With transmit enabled, wait for FIFO data, then send stored widths.
// - Clearing transmit enable mid-send still drains the FIFO first.
// - Sample unit select: 1, 25, 50 or 100 microseconds.
// - No carrier pulse mode in the 1 microsecond setting.
// - Normal input polarity: invert bit 0 means high is carrier on.
// - Wide-band input uses its own invert bit the same way.
// - Status flags are sticky; writing 1 clears, 0 leaves them.
// - Status positions: ready, trigger, end, overrun, empty, trig, under, min.
// - Receive overrun raises data ready in the same cycle.
// - Minimum length flag on a received pulse shorter than the minimum.
// - Interrupt enable mirrors status; 1 passes a flag, 0 masks it.
// - Interrupt holds until its status bit is written with 1 or its enable bit with 0.
// - Packet end when frame length reaches the 16-bit limit.
// - Carrier period 2 x 4^prescale x (period+1) clocks; zeros mean none.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module cirx_core #(
  parameter int DEPTH = 32,
  parameter logic [6:0] MIN_WIDTH = 7'h04
) (
  input wire logic CLK,
  input wire logic RST,
  input wire cirx_pkg::cirx_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic IR_RX,
  input wire logic WB_RX,
  output logic IR_TX,
  output logic IRQ
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);
  localparam logic [6:0] RUN_MAX = 7'h7F;

  logic [7:0] cfg_ff, sts_ff, ien_ff, cpre_ff, cper_ff;
  logic [7:0] limh_ff, liml_ff, fcfg_ff, rdata_ff;
  logic rxn_s1_ff, rxn_s2_ff, rxw_s1_ff, rxw_s2_ff;
  logic [9:0] tick_cnt_ff;
  logic [9:0] unit_m1;
  logic tick, rx_level, rx_en, tx_en, wr, rd;
  logic [7:0] sts_set, sts_clr, nxt_sts;
  logic [7:0] rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] rx_wp_ff, rx_rp_ff, tx_wp_ff, tx_rp_ff;
  logic [CW-1:0] rx_cnt_ff, tx_cnt_ff, rx_thr, tx_thr;
  logic rx_push, rx_pop, tx_push, tx_pop, rx_clr, tx_clr;
  logic rx_prev_ff, in_frame_ff, frame_hit;
  logic [6:0] run_ff;
  logic [15:0] frame_ff, limit;
  cirx_pkg::cirx_tx_state_t tx_state_ff;
  logic tx_level_ff, tx_out_ff, car_ph_ff, car_on, underrun;
  logic [6:0] tx_left_ff;
  logic [10:0] car_cnt_ff, car_half_m1;

  assign wr = REG_REQ.wr;
  assign rd = REG_REQ.rd;
  assign rx_en = cfg_ff[cirx_pkg::CFG_RX_EN];
  assign tx_en = cfg_ff[cirx_pkg::CFG_TX_EN];

  //////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_ff <= cirx_pkg::CFG_RST;
      ien_ff <= cirx_pkg::ZERO_RST;
      cpre_ff <= cirx_pkg::ZERO_RST;
      cper_ff <= cirx_pkg::ZERO_RST;
      limh_ff <= cirx_pkg::ZERO_RST;
      liml_ff <= cirx_pkg::ZERO_RST;
      fcfg_ff <= cirx_pkg::ZERO_RST;
    end else begin
      // FIFO clear bits act once and fall back
      fcfg_ff[cirx_pkg::FCFG_TXCLR] <= 1'b0;
      fcfg_ff[cirx_pkg::FCFG_RXCLR] <= 1'b0;
      if (wr) begin
        unique case (REG_REQ.addr)
          cirx_pkg::OFS_CFG: cfg_ff <= REG_REQ.wdata;
          cirx_pkg::OFS_IEN: ien_ff <= REG_REQ.wdata;
          cirx_pkg::OFS_CPRE: cpre_ff <= REG_REQ.wdata;
          cirx_pkg::OFS_CPER: cper_ff <= REG_REQ.wdata;
          cirx_pkg::OFS_LIMH: limh_ff <= REG_REQ.wdata;
          cirx_pkg::OFS_LIML: liml_ff <= REG_REQ.wdata;
          cirx_pkg::OFS_FCFG: fcfg_ff <= REG_REQ.wdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_ff <= cirx_pkg::ZERO_RST;
    end else if (rd) begin
      unique case (REG_REQ.addr)
        cirx_pkg::OFS_CFG: rdata_ff <= cfg_ff;
        cirx_pkg::OFS_STS: rdata_ff <= sts_ff;
        cirx_pkg::OFS_IEN: rdata_ff <= ien_ff;
        cirx_pkg::OFS_RXLVL: rdata_ff <= 8'(rx_cnt_ff);
        cirx_pkg::OFS_CPRE: rdata_ff <= cpre_ff;
        cirx_pkg::OFS_CPER: rdata_ff <= cper_ff;
        cirx_pkg::OFS_LIMH: rdata_ff <= limh_ff;
        cirx_pkg::OFS_LIML: rdata_ff <= liml_ff;
        cirx_pkg::OFS_FCFG: rdata_ff <= fcfg_ff;
        cirx_pkg::OFS_FSTATE: rdata_ff <= {IRQ, 1'b0,
            rx_cnt_ff >= rx_thr, rx_cnt_ff == '0, rx_cnt_ff == FULL,
            tx_cnt_ff <= tx_thr, tx_cnt_ff == '0, tx_cnt_ff == FULL};
        cirx_pkg::OFS_RXPOP: rdata_ff <= rx_mem[rx_rp_ff];
        cirx_pkg::OFS_TXLVL: rdata_ff <= 8'(tx_cnt_ff);
        cirx_pkg::OFS_FRMH: rdata_ff <= frame_ff[15:8];
        cirx_pkg::OFS_FRML: rdata_ff <= frame_ff[7:0];
        cirx_pkg::OFS_FSM: rdata_ff <= {1'b0, in_frame_ff, rx_prev_ff,
            rx_en, 1'b0, tx_state_ff};
        default: rdata_ff <= cirx_pkg::ZERO_RST;
      endcase
    end else begin
      rdata_ff <= cirx_pkg::ZERO_RST;
    end
  end
  assign REG_RDATA = rdata_ff;

  //////////////////////////////////////////////////////////////////////////
  // Status and interrupt

  always_comb begin
    sts_set = '0;
    sts_set[cirx_pkg::ST_RDR] = rx_push;
    sts_set[cirx_pkg::ST_RTR] = rx_push && rx_cnt_ff != FULL
        && rx_cnt_ff + ONE == rx_thr;
    sts_set[cirx_pkg::ST_PE] = rx_en && tick && in_frame_ff && frame_hit;
    sts_set[cirx_pkg::ST_RFO] = rx_push && rx_cnt_ff == FULL;
    sts_set[cirx_pkg::ST_TE] = tx_pop && tx_cnt_ff == ONE;
    sts_set[cirx_pkg::ST_TTR] = tx_pop && tx_cnt_ff - ONE == tx_thr;
    sts_set[cirx_pkg::ST_TFU] = underrun;
    sts_set[cirx_pkg::ST_GH] = rx_push && rx_prev_ff
        && run_ff < MIN_WIDTH;
    sts_clr = (wr && REG_REQ.addr == cirx_pkg::OFS_STS) ?
        REG_REQ.wdata : 8'h00;
    // Set beats clear so an event landing on a clear is kept
    nxt_sts = (sts_ff & ~sts_clr) | sts_set;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sts_ff <= cirx_pkg::ZERO_RST;
    end else begin
      sts_ff <= nxt_sts;
    end
  end

  // Level output from flops; only a status clear or an enable clear can drop it
  assign IRQ = |(sts_ff & ien_ff);

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers and sample tick

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rxn_s1_ff <= 1'b0;
      rxn_s2_ff <= 1'b0;
      rxw_s1_ff <= 1'b0;
      rxw_s2_ff <= 1'b0;
    end else begin
      rxn_s1_ff <= IR_RX;
      rxn_s2_ff <= rxn_s1_ff;
      rxw_s1_ff <= WB_RX;
      rxw_s2_ff <= rxw_s1_ff;
    end
  end

  assign rx_level = cfg_ff[cirx_pkg::CFG_WB_EN] ?
      (rxw_s2_ff ^ cfg_ff[cirx_pkg::CFG_WB_INV]) :
      (rxn_s2_ff ^ cfg_ff[cirx_pkg::CFG_N_INV]);

  always_comb begin
    unique case (cfg_ff[cirx_pkg::CFG_SEL_HI:cirx_pkg::CFG_SEL_LO])
      cirx_pkg::SEL_1US: unit_m1 = cirx_pkg::SAMP0_CYC - 10'h001;
      cirx_pkg::SEL_25US: unit_m1 = cirx_pkg::SAMP1_CYC - 10'h001;
      cirx_pkg::SEL_50US: unit_m1 = cirx_pkg::SAMP2_CYC - 10'h001;
      default: unit_m1 = cirx_pkg::SAMP3_CYC - 10'h001;
    endcase
  end
  // Compare with >= so a shorter unit chosen mid-count cannot wrap
  assign tick = tick_cnt_ff >= unit_m1;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tick_cnt_ff <= 10'h000;
    end else begin
      tick_cnt_ff <= tick ? 10'h000 : tick_cnt_ff + 10'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver: run lengths, bit 7 level, bits 6:0 width in units

  assign limit = {limh_ff, liml_ff};
  assign frame_hit = limit != 16'h0000 && frame_ff == limit;
  assign rx_push = rx_en && tick && in_frame_ff && (frame_hit
      || rx_level != rx_prev_ff || run_ff == RUN_MAX);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_prev_ff <= 1'b0;
      in_frame_ff <= 1'b0;
      run_ff <= 7'h00;
      frame_ff <= 16'h0000;
    end else if (!rx_en) begin
      in_frame_ff <= 1'b0;
      run_ff <= 7'h00;
    end else if (tick) begin
      rx_prev_ff <= rx_level;
      if (!in_frame_ff) begin
        if (rx_level) begin
          in_frame_ff <= 1'b1;
          run_ff <= 7'h01;
          frame_ff <= 16'h0001;
        end
      end else if (frame_hit) begin
        in_frame_ff <= 1'b0;
        run_ff <= 7'h00;
      end else begin
        frame_ff <= frame_ff + 16'h0001;
        if (rx_level != rx_prev_ff || run_ff == RUN_MAX) begin
          run_ff <= 7'h01;
        end else begin
          run_ff <= run_ff + 7'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // FIFOs; overflowing writes are dropped

  assign rx_thr = CW'({3'(fcfg_ff[cirx_pkg::FCFG_RXTRIG_LO +: 2]) + 3'h1,
      3'h0});
  assign tx_thr = CW'({fcfg_ff[cirx_pkg::FCFG_TXTRIG_LO +: 2], 3'h0});
  assign rx_clr = fcfg_ff[cirx_pkg::FCFG_RXCLR];
  assign tx_clr = fcfg_ff[cirx_pkg::FCFG_TXCLR];
  assign rx_pop = rd && REG_REQ.addr == cirx_pkg::OFS_RXPOP
      && rx_cnt_ff != '0;
  assign tx_push = wr && REG_REQ.addr == cirx_pkg::OFS_TXPUSH
      && tx_cnt_ff != FULL;
  assign tx_pop = tx_state_ff == cirx_pkg::TX_LOAD;

  always_ff @(posedge CLK) begin
    if (rx_push && rx_cnt_ff != FULL) begin
      rx_mem[rx_wp_ff] <= {rx_prev_ff, run_ff};
    end
    if (tx_push) begin
      tx_mem[tx_wp_ff] <= REG_REQ.wdata;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_wp_ff <= '0;
      rx_rp_ff <= '0;
      rx_cnt_ff <= '0;
    end else if (rx_clr) begin
      rx_wp_ff <= '0;
      rx_rp_ff <= '0;
      rx_cnt_ff <= '0;
    end else begin
      if (rx_push && rx_cnt_ff != FULL) begin
        rx_wp_ff <= rx_wp_ff + AW'(1);
      end
      if (rx_pop) begin
        rx_rp_ff <= rx_rp_ff + AW'(1);
      end
      if ((rx_push && rx_cnt_ff != FULL) && !rx_pop) begin
        rx_cnt_ff <= rx_cnt_ff + ONE;
      end else if (rx_pop && !(rx_push && rx_cnt_ff != FULL)) begin
        rx_cnt_ff <= rx_cnt_ff - ONE;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_wp_ff <= '0;
      tx_rp_ff <= '0;
      tx_cnt_ff <= '0;
    end else if (tx_clr) begin
      tx_wp_ff <= '0;
      tx_rp_ff <= '0;
      tx_cnt_ff <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_ff <= tx_wp_ff + AW'(1);
      end
      if (tx_pop) begin
        tx_rp_ff <= tx_rp_ff + AW'(1);
      end
      if (tx_push && !tx_pop) begin
        tx_cnt_ff <= tx_cnt_ff + ONE;
      end else if (tx_pop && !tx_push) begin
        tx_cnt_ff <= tx_cnt_ff - ONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmitter sequencer and carrier

  assign underrun = tx_state_ff == cirx_pkg::TX_SEND && tick
      && tx_left_ff <= 7'h01 && tx_cnt_ff == '0 && tx_en;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_state_ff <= cirx_pkg::TX_IDLE;
      tx_level_ff <= 1'b0;
      tx_left_ff <= 7'h00;
    end else begin
      unique case (tx_state_ff)
        cirx_pkg::TX_IDLE: begin
          if (tx_en && tx_cnt_ff != '0 && !tx_clr) begin
            tx_state_ff <= cirx_pkg::TX_LOAD;
          end
        end
        cirx_pkg::TX_LOAD: begin
          tx_level_ff <= tx_mem[tx_rp_ff][7];
          tx_left_ff <= tx_mem[tx_rp_ff][6:0];
          tx_state_ff <= cirx_pkg::TX_SEND;
        end
        cirx_pkg::TX_SEND: begin
          if (tx_clr) begin
            tx_state_ff <= cirx_pkg::TX_IDLE;
          end else if (tick) begin
            // Zero width is sent as one unit
            if (tx_left_ff <= 7'h01) begin
              // Enable is not looked at here: queued data always drains
              tx_state_ff <= (tx_cnt_ff != '0) ?
                  cirx_pkg::TX_LOAD : cirx_pkg::TX_IDLE;
            end else begin
              tx_left_ff <= tx_left_ff - 7'h01;
            end
          end
        end
      endcase
    end
  end

  assign car_on = cpre_ff[cirx_pkg::CPRE_MODE]
      && cfg_ff[cirx_pkg::CFG_SEL_HI:cirx_pkg::CFG_SEL_LO]
      != cirx_pkg::SEL_1US
      && !(cpre_ff[cirx_pkg::CPRE_BIT] == 1'b0 && cper_ff == 8'h00);
  // Half period is 4^prescale x (period+1) clocks
  assign car_half_m1 = cpre_ff[cirx_pkg::CPRE_BIT] ?
      11'({cper_ff, 2'h3}) : 11'(cper_ff);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      car_cnt_ff <= 11'h000;
      car_ph_ff <= 1'b0;
    end else if (!car_on || tx_state_ff != cirx_pkg::TX_SEND) begin
      car_cnt_ff <= 11'h000;
      car_ph_ff <= 1'b1;
    end else if (car_cnt_ff >= car_half_m1) begin
      car_cnt_ff <= 11'h000;
      car_ph_ff <= ~car_ph_ff;
    end else begin
      car_cnt_ff <= car_cnt_ff + 11'h001;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_out_ff <= 1'b0;
    end else begin
      tx_out_ff <= tx_state_ff == cirx_pkg::TX_SEND && tx_level_ff
          && (!car_on || car_ph_ff);
    end
  end
  assign IR_TX = tx_out_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  // Sample unit field, named once for the checks below
  logic [1:0] samp_sel;
  assign samp_sel = cfg_ff[cirx_pkg::CFG_SEL_HI:cirx_pkg::CFG_SEL_LO];

  property p_tx_start;
    @(posedge CLK) disable iff (RST)
    (tx_state_ff == cirx_pkg::TX_IDLE && tx_en && tx_cnt_ff != '0
        && !tx_clr) |=> tx_state_ff == cirx_pkg::TX_LOAD;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("Transmit did not start on queued data");

  property p_tx_drain;
    @(posedge CLK) disable iff (RST)
    (tx_state_ff == cirx_pkg::TX_SEND && tick && !tx_clr
        && tx_left_ff <= 7'h01 && tx_cnt_ff != '0)
        |=> tx_state_ff == cirx_pkg::TX_LOAD;
  endproperty
  a_tx_drain: assert property (p_tx_drain)
    else $error("Transmit stopped with data queued");

  // Select must hold up to the tick itself, else the unit may change
  property p_unit_1us;
    @(posedge CLK) disable iff (RST)
    (tick && samp_sel == cirx_pkg::SEL_1US)
        ##1 (samp_sel == cirx_pkg::SEL_1US)[*8]
        ##1 (samp_sel == cirx_pkg::SEL_1US)[*2] |-> tick;
  endproperty
  a_unit_1us: assert property (p_unit_1us)
    else $error("Sample tick not every ten clocks");

  property p_no_pulse_1us;
    @(posedge CLK) disable iff (RST)
    (tx_state_ff == cirx_pkg::TX_SEND && tx_level_ff
        && samp_sel == cirx_pkg::SEL_1US) |=> IR_TX;
  endproperty
  a_no_pulse_1us: assert property (p_no_pulse_1us)
    else $error("Carrier applied in one microsecond mode");

  property p_sticky;
    @(posedge CLK) disable iff (RST)
    1'b1 |=> (sts_ff & $past(sts_ff & ~sts_clr))
        == $past(sts_ff & ~sts_clr);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Status flag dropped without a clear");

  property p_overrun_ready;
    @(posedge CLK) disable iff (RST)
    $rose(sts_ff[cirx_pkg::ST_RFO]) |-> sts_ff[cirx_pkg::ST_RDR];
  endproperty
  a_overrun_ready: assert property (p_overrun_ready)
    else $error("Overrun raised without data ready");

  property p_irq;
    @(posedge CLK) disable iff (RST)
    // Masking through the enable register is the one other way down
    ((sts_ff & ien_ff) != 8'h00 && sts_clr == 8'h00
        && !(wr && REG_REQ.addr == cirx_pkg::OFS_IEN)) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt dropped without a status clear");

  property p_packet_end;
    @(posedge CLK) disable iff (RST)
    (rx_en && tick && in_frame_ff && frame_hit)
        |=> sts_ff[cirx_pkg::ST_PE] && !in_frame_ff;
  endproperty
  a_packet_end: assert property (p_packet_end)
    else $error("Packet end missing at limit");

  property p_rx_off;
    @(posedge CLK) disable iff (RST)
    !rx_en |-> !rx_push;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("Receive store while disabled");

endmodule // cirx_core

/* pkg/cirx_pkg.sv */
// Constants and types for the consumer infrared transceiver block
package cirx_pkg;
  // Register offsets
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_STS = 4'h1;
  localparam logic [3:0] OFS_IEN = 4'h2;
  localparam logic [3:0] OFS_RXLVL = 4'h3;
  localparam logic [3:0] OFS_CPRE = 4'h4;
  localparam logic [3:0] OFS_CPER = 4'h5;
  localparam logic [3:0] OFS_LIMH = 4'h6;
  localparam logic [3:0] OFS_LIML = 4'h7;
  localparam logic [3:0] OFS_FCFG = 4'h8;
  localparam logic [3:0] OFS_FSTATE = 4'h9;
  localparam logic [3:0] OFS_RXPOP = 4'hA;
  localparam logic [3:0] OFS_TXLVL = 4'hB;
  localparam logic [3:0] OFS_TXPUSH = 4'hC;
  localparam logic [3:0] OFS_FRMH = 4'hD;
  localparam logic [3:0] OFS_FRML = 4'hE;
  localparam logic [3:0] OFS_FSM = 4'hF;
  // Reset values
  localparam logic [7:0] CFG_RST = 8'h04;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // Configuration fields
  localparam int CFG_WB_EN = 6;
  localparam int CFG_TX_EN = 5;
  localparam int CFG_RX_EN = 4;
  localparam int CFG_WB_INV = 3;
  localparam int CFG_N_INV = 2;
  localparam int CFG_SEL_HI = 1;
  localparam int CFG_SEL_LO = 0;
  // Status and enable layout
  localparam int ST_RDR = 7;
  localparam int ST_RTR = 6;
  localparam int ST_PE = 5;
  localparam int ST_RFO = 4;
  localparam int ST_TE = 3;
  localparam int ST_TTR = 2;
  localparam int ST_TFU = 1;
  localparam int ST_GH = 0;
  // Carrier and FIFO control fields
  localparam int CPRE_MODE = 7;
  localparam int CPRE_BIT = 0;
  localparam int FCFG_TXCLR = 7;
  localparam int FCFG_RXCLR = 3;
  localparam int FCFG_TXTRIG_LO = 4;
  localparam int FCFG_RXTRIG_LO = 0;
  // Sample period selection
  localparam logic [1:0] SEL_1US = 2'h0;
  localparam logic [1:0] SEL_25US = 2'h1;
  localparam logic [1:0] SEL_50US = 2'h2;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMP0_US = 1;
  localparam int SAMP1_US = 25;
  localparam int SAMP2_US = 50;
  localparam int SAMP3_US = 100;
  localparam logic [9:0] SAMP0_CYC = 10'(SAMP0_US * (CLK_HZ / 1_000_000));
  localparam logic [9:0] SAMP1_CYC = 10'(SAMP1_US * (CLK_HZ / 1_000_000));
  localparam logic [9:0] SAMP2_CYC = 10'(SAMP2_US * (CLK_HZ / 1_000_000));
  localparam logic [9:0] SAMP3_CYC = 10'(SAMP3_US * (CLK_HZ / 1_000_000));
  // Transmit sequencer states
  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_LOAD = 3'h2,
    TX_SEND = 3'h4
  } cirx_tx_state_t;
  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cirx_req_t;
endpackage

/* tb/cirx_dongle.sv */
// Behavioural infrared dongle facing the transceiver
`timescale 1ns/100ps
module cirx_dongle (
  input wire logic clk,
  input wire logic light,
  input wire logic inv,
  input wire logic use_wb,
  input wire logic ir_tx,
  input wire logic clr,
  output logic ir_rx,
  output logic wb_rx,
  output logic [15:0] lit_cnt,
  output logic [15:0] max_run
);
  logic [15:0] run_ff;
  // Unused line rests at its idle level
  assign ir_rx = (light & ~use_wb) ^ inv;
  assign wb_rx = (light & use_wb) ^ inv;
  ////////////////////////////////////////////////////////////
  // Light meter: total lit time and longest lit run
  always_ff @(posedge clk) begin
    if (clr) begin
      lit_cnt <= 16'h0000;
      max_run <= 16'h0000;
      run_ff <= 16'h0000;
    end else if (ir_tx) begin
      lit_cnt <= lit_cnt + 16'h0001;
      run_ff <= run_ff + 16'h0001;
      if (run_ff + 16'h0001 > max_run) begin
        max_run <= run_ff + 16'h0001;
      end
    end else begin
      run_ff <= 16'h0000;
    end
  end
endmodule // cirx_dongle

/* tb/testbench.sv */
// Self-checking bench for the infrared transceiver block
`timescale 1ns/100ps
module testbench;
  logic clk, rst, ir_rx, wb_rx, ir_tx, irq, light, inv, use_wb, clr;
  cirx_pkg::cirx_req_t req;
  logic [7:0] rdata, v;
  logic [15:0] lit_cnt, max_run;
  logic [19:0] exp_q[$];
  logic [19:0] note;
  logic rd_seen;
  int errors, n_checks, seed, u, lo, hi;

  cirx_core #(.DEPTH(32), .MIN_WIDTH(7'h04)) u_cirx_core (.CLK(clk),
    .RST(rst), .REG_REQ(req), .REG_RDATA(rdata), .IR_RX(ir_rx),
    .WB_RX(wb_rx), .IR_TX(ir_tx), .IRQ(irq));
  cirx_dongle u_cirx_dongle (.clk(clk), .light(light), .inv(inv),
    .use_wb(use_wb), .ir_tx(ir_tx), .clr(clr), .ir_rx(ir_rx),
    .wb_rx(wb_rx), .lit_cnt(lit_cnt), .max_run(max_run));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // Notes the masked expectation; the watcher compares it
  task automatic rd(input logic [3:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    exp_q.push_back({a, m, e & m});
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
  endtask
  task automatic pulse(input int on_c, input int off_c);
    @(posedge clk);
    light <= 1'b1;
    cyc(on_c);
    light <= 1'b0;
    cyc(off_c);
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk);
    chk("irq", {7'h00, irq}, {7'h00, e});
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk) rd_seen <= req.rd;
  // Read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      note = exp_q.pop_front();
      chk($sformatf("reg %h", note[19:16]), rdata & note[15:8], note[7:0]);
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(100 * 30000);
    errors++;
    test_done();
  end
  initial begin
    seed = 32'h88EE;
    errors = 0;
    n_checks = 0;
    rst = 1'b1;
    req = '0;
    light = 1'b0;
    inv = 1'b0;
    use_wb = 1'b0;
    clr = 1'b1;
    rd_seen = 1'b0;
    cyc(2);
    rst <= 1'b0;
    clr <= 1'b0;
    rd(4'h0, 8'hFF, cirx_pkg::CFG_RST);
    rd(4'h1, 8'hFF, 8'h00);
    rd(4'h2, 8'hFF, 8'h00);
    wr(4'h3, 8'h5A);
    rd(4'h3, 8'hFF, 8'h00);
    rd(4'hC, 8'hFF, 8'h00);
    for (int a = 4; a < 8; a++) begin
      v = 8'($random(seed));
      wr(4'(a), v);
      rd(4'(a), 8'hFF, v);
      wr(4'(a), 8'h00);
    end
    // Short run must flag, long run must not: normal, inverted and inverted wide-band input
    for (int k = 0; k < 3; k++) begin
      inv <= (k != 0);
      use_wb <= (k == 2);
      wr(4'h0, (k == 0) ? 8'h10 : (k == 1) ? 8'h14 : 8'h5C);
      cyc(40);
      wr(4'h1, 8'hFF);
      pulse(20, 60);
      rd(4'h1, 8'h01, 8'h01);
      wr(4'h1, 8'hFF);
      pulse(100, 60);
      rd(4'h1, 8'h01, 8'h00);
    end
    inv <= 1'b0;
    use_wb <= 1'b0;
    wr(4'h0, 8'h00);
    wr(4'h8, 8'h08);
    cyc(40);
    wr(4'h1, 8'hFF);
    pulse(20, 60);
    rd(4'h1, 8'hFF, 8'h00);
    rd(4'h3, 8'hFF, 8'h00);
    wr(4'h0, 8'h10);
    wr(4'h2, 8'h01);
    cyc(40);
    wr(4'h1, 8'hFF);
    pulse(20, 60);
    irq_is(1'b1);
    wr(4'h1, 8'hFE);
    irq_is(1'b1);
    wr(4'h2, 8'h00);
    irq_is(1'b0);
    wr(4'h2, 8'h01);
    irq_is(1'b1);
    wr(4'h1, 8'h01);
    irq_is(1'b0);
    // Flood the receive store past its depth
    wr(4'h8, 8'h08);
    wr(4'h1, 8'hFF);
    repeat (20) pulse(20, 20);
    rd(4'h1, 8'hD0, 8'hD0);
    rd(4'h3, 8'hFF, 8'h20);
    // Head holds the idle run, then the first two-unit lit run
    rd(4'hA, 8'h80, 8'h00);
    rd(4'hA, 8'hFF, 8'h82);
    rd(4'h3, 8'hFF, 8'h1E);
    // Fresh frame against a five-unit limit must end in packet end
    wr(4'h0, 8'h00);
    wr(4'h7, 8'h05);
    wr(4'h0, 8'h10);
    wr(4'h1, 8'hFF);
    rd(4'h1, 8'h20, 8'h00);
    pulse(100, 60);
    rd(4'h1, 8'h20, 8'h20);
    wr(4'h7, 8'h00);
    wr(4'h0, 8'h20);
    cyc(50);
    chk("idle light", lit_cnt[7:0], 8'h00);
    wr(4'h1, 8'hFF);
    wr(4'hC, 8'h83);
    wr(4'hC, 8'h02);
    cyc(120);
    chk("tx lit", 8'(lit_cnt > 20 && lit_cnt <= 32), 8'h01);
    rd(4'h1, 8'h0A, 8'h0A);
    clr <= 1'b1;
    wr(4'h1, 8'hFF);
    clr <= 1'b0;
    wr(4'hC, 8'h83);
    wr(4'hC, 8'h83);
    wr(4'h0, 8'h00);
    cyc(100);
    chk("drain lit", 8'(lit_cnt > 40 && lit_cnt <= 64), 8'h01);
    rd(4'h1, 8'h0A, 8'h08);
    // Pulse mode at each sample unit; none in the fastest one
    wr(4'h4, 8'h80);
    wr(4'h5, 8'h01);
    for (int s = 0; s < 4; s++) begin
      u = (s == 0) ? 10 : (s == 1) ? 250 : (s == 2) ? 500 : 1000;
      lo = (s == 0) ? u : u / 2 - 2;
      hi = (s == 0) ? 2 * u + 2 : u + 2;
      wr(4'h0, 8'h20 | 8'(s));
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      wr(4'hC, 8'h82);
      cyc(2 * u + 20);
      chk("tx width", 8'(lit_cnt > lo && lit_cnt <= hi), 8'h01);
      if (s == 0) begin
        chk("dc run", 8'(max_run == lit_cnt), 8'h01);
      end else begin
        chk("carrier run", max_run[7:0], 8'h02);
      end
    end
    cyc(5);
    test_done();
  end
endmodule // testbench
